// ==== include/asmf_pkg.sv ====
package asmf_pkg;
   // Register byte addresses; halfword big-endian access adds HALF_BE_LANE.
   localparam logic [31:0] ADDR_CONTROL   = 32'h1550_8000;
   localparam logic [31:0] ADDR_MODE      = 32'h1550_8004;
   localparam logic [31:0] ADDR_PRESCALE  = 32'h1550_8008;
   localparam logic [31:0] ADDR_FIFO_CTRL = 32'h1550_800C;
   localparam logic [31:0] ADDR_FIFO_PORT = 32'h1550_8010;
   localparam logic [1:0]  HALF_BE_LANE   = 2'h2;
   // Access size codes on the processor port.
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   // Control register fields.
   localparam int CTL_ENABLE = 0;
   localparam int CTL_PRE_EN = 1;
   localparam int CTL_RX_IDLE = 2;
   localparam int CTL_TX_IDLE = 3;
   localparam int CTL_RX_DMA = 4;
   localparam int CTL_TX_DMA = 5;
   localparam int CTL_WR_W = 6;
   // Mode register fields.
   localparam int MODE_W = 9;
   localparam int MODE_ROLE = 8;
   localparam int MODE_TX = 7;
   localparam int MODE_RX = 6;
   localparam int MODE_POL = 5;
   localparam int MODE_FMT = 4;
   localparam int MODE_WID = 3;
   localparam int MODE_MCLK = 2;
   localparam int MODE_BCLK_HI = 1;
   // Prescaler register fields.
   localparam int PSR_W = 10;
   localparam int PSR_A_LO = 5;
   localparam int PSR_B_LO = 0;
   localparam int PSR_N_W = 5;
   // FIFO control fields; the writable part is bits 11:8.
   localparam int FC_TX_DMA = 3;
   localparam int FC_RX_DMA = 2;
   localparam int FC_TX_EN = 1;
   localparam int FC_RX_EN = 0;
   localparam int FC_WR_W = 4;
   localparam int FC_WR_LO = 8;
   localparam int CNT_W = 4;
   // Reset values of the writable parts.
   localparam logic [CTL_WR_W-1:0] CTL_RST = 6'h00;
   localparam logic [MODE_W-1:0]   MODE_RST = 9'h000;
   localparam logic [PSR_W-1:0]    PSR_RST = 10'h000;
   localparam logic [FC_WR_W-1:0]  FC_RST = 4'h0;
   // FIFO shape and indices.
   localparam int FIFO_W = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_TX = 0;
   localparam int FIFO_RX = 1;
   // Serial engine constants.
   localparam logic [4:0] BITS_8 = 5'h08;
   localparam logic [4:0] BITS_16 = 5'h10;
   localparam logic [4:0] BIT_IDLE = 5'h1F;
   localparam logic LR_RST = 1'b1;

   // Master clock ticks per bit clock half period.
   function automatic logic [4:0] half_period(input logic m384, input logic [1:0] r);
      case ({m384, r})
         3'b000:  half_period = 5'h08;
         3'b001:  half_period = 5'h04;
         3'b010:  half_period = 5'h03;
         3'b100:  half_period = 5'h0C;
         3'b101:  half_period = 5'h06;
         3'b110:  half_period = 5'h04;
         3'b111:  half_period = 5'h06;
         default: half_period = 5'h04;
      endcase
   endfunction

   // Bit clocks per channel slot: 16fs, 32fs, 48fs, reserved as 32fs.
   function automatic logic [4:0] slot_bits(input logic [1:0] r);
      case (r)
         2'b00:   slot_bits = 5'h08;
         2'b01:   slot_bits = 5'h10;
         2'b10:   slot_bits = 5'h18;
         default: slot_bits = 5'h10;
      endcase
   endfunction
endpackage

// ==== rtl/asmf_core.sv ====
`timescale 1ns/1ps
module asmf_core #(
   parameter int DEPTH = asmf_pkg::FIFO_DEPTH // Entries per FIFO.
) (
   input  wire logic        clk_i,                   // System clock.
   input  wire logic        rst_i,                   // Synchronous reset.
   input  wire logic [31:0] bus_addr_i,              // Byte address.
   input  wire logic        bus_wr_i,                // Write strobe.
   input  wire logic        bus_rd_i,                // Read strobe.
   input  wire logic [1:0]  bus_size_i,              // Access size.
   input  wire logic        bus_big_endian_i,        // Big-endian mode.
   input  wire logic [31:0] bus_wdata_i,             // Write data, low aligned.
   output logic      [31:0] bus_rdata_o,             // Read data.
   output logic             bus_ack_o,               // Access accepted.
   output logic             bus_err_o,               // Access refused.
   input  wire logic        serial_bit_clock_i,      // Bit clock pin in.
   output logic             serial_bit_clock_o,      // Bit clock pin out.
   output logic             serial_bit_clock_oe_n_o, // Bit clock drive, low.
   input  wire logic        frame_select_line_i,     // Frame select in.
   output logic             frame_select_line_o,     // Frame select out.
   output logic             frame_select_line_oe_n_o,// Frame select drive, low.
   input  wire logic        serial_data_in_i,        // Serial data in.
   output logic             serial_data_out_o,       // Serial data out.
   output logic             codec_clk_o,             // Codec master clock.
   output logic             tx_dma_req_o,            // Transmit DMA request.
   output logic             rx_dma_req_o             // Receive DMA request.
);
   import asmf_pkg::*;

   localparam int PW = $clog2(DEPTH);   // FIFO pointer width.
   localparam int CW = $clog2(DEPTH + 1); // FIFO count width.

   // Register state and next values.
   logic [CTL_WR_W-1:0] ctl_ff, nxt_ctl;      // Control, writable bits.
   logic [MODE_W-1:0]   mode_ff, nxt_mode;    // Mode configuration.
   logic [PSR_W-1:0]    psr_ff, nxt_psr;      // Prescaler values.
   logic [FC_WR_W-1:0]  fc_ff, nxt_fc;        // FIFO control, writable bits.
   logic [31:0]         rdata_ff, nxt_rdata;  // Read data holding register.
   logic                ack_ff, nxt_ack;      // Accept pulse.
   logic                err_ff, nxt_err;      // Refuse pulse.

   // FIFO request lines and views.
   logic              tx_push, tx_pop, rx_push, rx_pop; // FIFO strobes.
   logic [15:0]       tx_wdata, rx_wdata;     // Data pushed.
   logic [1:0]        f_push, f_pop, f_en;    // Per-FIFO strobes and enables.
   logic [15:0]       f_wdata [2];            // Per-FIFO push data.
   logic [15:0]       f_head [2];             // Per-FIFO oldest entry.
   logic [CW-1:0]     f_cnt [2];              // Per-FIFO fill count.
   logic              tx_rdy, rx_rdy;         // Ready flags.
   logic              lr_right;               // Right channel index.

   // Prescaler state.
   logic [PSR_N_W-1:0] pa_ff, nxt_pa, pb_ff, nxt_pb; // Divider counters.
   logic               cclk_ff, nxt_cclk;     // Codec clock level.
   logic               mclk_tick;             // Internal master clock tick.

   // Pin synchronisers.
   logic sck_s1, sck_s2, sck_s3;              // Bit clock sync and delay.
   logic lr_s1, lr_s2;                        // Frame select sync.
   logic sdi_s1, sdi_s2;                      // Data in sync.

   // Serial engine state.
   logic       bclk_ff, nxt_bclk;             // Generated bit clock.
   logic [4:0] hcnt_ff, nxt_hcnt;             // Half period counter.
   logic [4:0] slot_ff, nxt_slot;             // Bits sent in slot.
   logic       lr_ff, nxt_lr;                 // Current frame select.
   logic       seen_ff, nxt_seen;             // Frame select at last fall.
   logic       pend_ff, nxt_pend;             // Load due at next fall.
   logic [15:0] txsh_ff, nxt_txsh;            // Transmit shifter.
   logic [15:0] rxsh_ff, nxt_rxsh;            // Receive shifter.
   logic [4:0]  bit_ff, nxt_bit;              // Bits captured in word.

   // Bus decode, register writes, reads, and FIFO port strobes.
   always_comb begin
      logic [31:0] base;
      logic [1:0]  lane;
      logic [1:0]  bl;
      logic        pos_ok;
      logic        any_size;
      logic        hit;
      logic [31:0] cur;
      logic [31:0] wv;
      base = {bus_addr_i[31:2], 2'b00};
      lane = bus_addr_i[1:0];
      bl = bus_big_endian_i ? ~lane : lane;
      nxt_ctl = ctl_ff;
      nxt_mode = mode_ff;
      nxt_psr = psr_ff;
      nxt_fc = fc_ff;
      nxt_rdata = rdata_ff;
      nxt_ack = 1'b0;
      nxt_err = 1'b0;
      tx_push = 1'b0;
      rx_pop = 1'b0;
      tx_wdata = bus_wdata_i[15:0];
      hit = 1'b1;
      any_size = 1'b0;
      pos_ok = 1'b0;
      cur = 32'h0000_0000;
      // Position check: halfword sits two up in big-endian mode.
      case (bus_size_i)
         SIZE_WORD: pos_ok = (lane == 2'h0);
         SIZE_HALF: pos_ok = (lane == (bus_big_endian_i ? HALF_BE_LANE : 2'h0));
         SIZE_BYTE: pos_ok = 1'b1;
         default:   pos_ok = 1'b0;
      endcase
      // Select the register and what it reads as.
      case (base)
         ADDR_CONTROL: begin
            any_size = 1'b1;
            cur = 32'({lr_right, tx_rdy, rx_rdy, ctl_ff});
         end
         ADDR_MODE: cur = 32'(mode_ff);
         ADDR_PRESCALE: begin
            any_size = 1'b1;
            cur = 32'(psr_ff);
         end
         ADDR_FIFO_CTRL: cur = 32'({fc_ff, CNT_W'(f_cnt[FIFO_TX]), CNT_W'(f_cnt[FIFO_RX])});
         ADDR_FIFO_PORT: cur = 32'(f_cnt[FIFO_RX] != '0 ? f_head[FIFO_RX] : 16'h0000);
         default: hit = 1'b0;
      endcase
      // Byte access is refused where only halfword and word are allowed.
      if (bus_size_i == SIZE_BYTE && !any_size) begin
         pos_ok = 1'b0;
      end
      wv = bus_wdata_i;
      if (bus_size_i == SIZE_BYTE) begin
         wv = cur;
         wv[{bl, 3'b000} +: 8] = bus_wdata_i[7:0];
      end
      if (bus_wr_i || bus_rd_i) begin
         if (hit && pos_ok) begin
            nxt_ack = 1'b1;
            if (bus_wr_i) begin
               case (base)
                  ADDR_CONTROL:   nxt_ctl = wv[CTL_WR_W-1:0];
                  ADDR_MODE:      nxt_mode = wv[MODE_W-1:0];
                  ADDR_PRESCALE:  nxt_psr = wv[PSR_W-1:0];
                  ADDR_FIFO_CTRL: nxt_fc = wv[FC_WR_LO +: FC_WR_W];
                  ADDR_FIFO_PORT: tx_push = 1'b1;
                  default:        nxt_ack = 1'b1;
               endcase
            end else begin
               nxt_rdata = (bus_size_i == SIZE_BYTE) ? 32'(cur[{bl, 3'b000} +: 8]) : cur;
               rx_pop = (base == ADDR_FIFO_PORT);
            end
         end else begin
            nxt_err = 1'b1;
            if (bus_rd_i) begin
               nxt_rdata = 32'h0000_0000;
            end
         end
      end
   end

   // Register the bus side state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_ff <= CTL_RST;
         mode_ff <= MODE_RST;
         psr_ff <= PSR_RST;
         fc_ff <= FC_RST;
         rdata_ff <= 32'h0000_0000;
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ctl_ff <= nxt_ctl;
         mode_ff <= nxt_mode;
         psr_ff <= nxt_psr;
         fc_ff <= nxt_fc;
         rdata_ff <= nxt_rdata;
         ack_ff <= nxt_ack;
         err_ff <= nxt_err;
      end
   end

   // Both FIFOs share one structure; index 0 transmits, index 1 receives.
   assign f_push = {rx_push, tx_push};
   assign f_pop = {rx_pop, tx_pop};
   assign f_en = {fc_ff[FC_RX_EN], fc_ff[FC_TX_EN]};
   assign f_wdata[FIFO_TX] = tx_wdata;
   assign f_wdata[FIFO_RX] = rx_wdata;
   for (genvar g = 0; g < 2; g++) begin : g_fifo
      logic [15:0]   mem_ff [DEPTH];           // Entry storage.
      logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp; // Pointers.
      logic [CW-1:0] cnt_ff, nxt_cnt;          // Fill count.
      logic          do_push, do_pop;          // Accepted strobes.
      // Push when not full, pop when not empty; disabling flushes.
      always_comb begin
         do_push = f_en[g] && f_push[g] && (cnt_ff != CW'(DEPTH));
         do_pop = f_en[g] && f_pop[g] && (cnt_ff != '0);
         nxt_wp = wp_ff + PW'(do_push);
         nxt_rp = rp_ff + PW'(do_pop);
         nxt_cnt = cnt_ff + CW'(do_push) - CW'(do_pop);
         if (!f_en[g]) begin
            nxt_wp = '0;
            nxt_rp = '0;
            nxt_cnt = '0;
         end
      end
      // Register pointers, count and the pushed entry.
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
         end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            if (do_push) begin
               mem_ff[wp_ff] <= f_wdata[g];
            end
         end
      end
      assign f_head[g] = mem_ff[rp_ff];
      assign f_cnt[g] = cnt_ff;
   end

   // Ready flags and DMA requests.
   assign tx_rdy = (f_cnt[FIFO_TX] != '0);
   assign rx_rdy = (f_cnt[FIFO_RX] != CW'(DEPTH));
   assign tx_dma_req_o = ctl_ff[CTL_TX_DMA] && fc_ff[FC_TX_DMA] && tx_rdy;
   assign rx_dma_req_o = ctl_ff[CTL_RX_DMA] && fc_ff[FC_RX_DMA] && rx_rdy;

   // Prescalers count 0..N, so each divides the system clock by N+1.
   always_comb begin
      logic [PSR_N_W-1:0] na;
      logic [PSR_N_W-1:0] nb;
      na = psr_ff[PSR_A_LO +: PSR_N_W];
      nb = psr_ff[PSR_B_LO +: PSR_N_W];
      mclk_tick = ctl_ff[CTL_PRE_EN] && (pa_ff >= na);
      nxt_pa = (!ctl_ff[CTL_PRE_EN] || pa_ff >= na) ? '0 : pa_ff + 1'b1;
      nxt_pb = (!ctl_ff[CTL_PRE_EN] || pb_ff >= nb) ? '0 : pb_ff + 1'b1;
      nxt_cclk = ctl_ff[CTL_PRE_EN] && (nxt_pb <= (nb >> 1));
   end

   // Register the prescaler counters.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pa_ff <= '0;
         pb_ff <= '0;
         cclk_ff <= 1'b0;
      end else begin
         pa_ff <= nxt_pa;
         pb_ff <= nxt_pb;
         cclk_ff <= nxt_cclk;
      end
   end

   // Two flip-flops on every pin input; sck_s3 only delays for edges.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {sck_s1, sck_s2, sck_s3} <= 3'h0;
         {lr_s1, lr_s2, sdi_s1, sdi_s2} <= 4'h0;
      end else begin
         {sck_s1, sck_s2, sck_s3} <= {serial_bit_clock_i, sck_s1, sck_s2};
         {lr_s1, lr_s2} <= {frame_select_line_i, lr_s1};
         {sdi_s1, sdi_s2} <= {serial_data_in_i, sdi_s1};
      end
   end

   // Serial engine: clocking, framing, shifting and FIFO traffic.
   always_comb begin
      logic       master;
      logic       rise;
      logic       fall;
      logic       start;
      logic       load;
      logic [4:0] width;
      logic [15:0] data;
      master = !mode_ff[MODE_ROLE];
      width = mode_ff[MODE_WID] ? BITS_16 : BITS_8;
      rise = 1'b0;
      fall = 1'b0;
      nxt_bclk = bclk_ff;
      nxt_hcnt = hcnt_ff;
      nxt_slot = slot_ff;
      nxt_lr = lr_ff;
      nxt_seen = seen_ff;
      nxt_pend = pend_ff;
      nxt_txsh = txsh_ff;
      nxt_rxsh = rxsh_ff;
      nxt_bit = bit_ff;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_wdata = 16'h0000;
      data = 16'h0000;
      if (master) begin
         // Half period in master ticks follows both ratio settings.
         if (mclk_tick) begin
            if (hcnt_ff >= half_period(mode_ff[MODE_MCLK], mode_ff[MODE_BCLK_HI:0]) - 5'h01) begin
               nxt_hcnt = 5'h00;
               nxt_bclk = ~bclk_ff;
               rise = ~bclk_ff;
               fall = bclk_ff;
            end else begin
               nxt_hcnt = hcnt_ff + 5'h01;
            end
         end
         // Frame select flips at a falling edge after a full slot.
         if (fall) begin
            if (slot_ff >= slot_bits(mode_ff[MODE_BCLK_HI:0]) - 5'h01) begin
               nxt_slot = 5'h00;
               nxt_lr = ~lr_ff;
            end else begin
               nxt_slot = slot_ff + 5'h01;
            end
         end
      end else begin
         // Slave follows the synchronised pins; frame select latched on rise.
         rise = sck_s2 && !sck_s3;
         fall = !sck_s2 && sck_s3;
         if (rise) begin
            nxt_lr = lr_s2;
         end
      end
      // A frame select change starts a word, at once or one bit later.
      start = fall && (nxt_lr != seen_ff);
      load = fall && (mode_ff[MODE_FMT] ? start : pend_ff);
      if (fall) begin
         nxt_seen = nxt_lr;
         nxt_pend = start && !mode_ff[MODE_FMT];
      end
      if (load) begin
         // Transmit only when selected, enabled and not paused.
         if (mode_ff[MODE_TX] && !ctl_ff[CTL_TX_IDLE] && f_cnt[FIFO_TX] != '0) begin
            tx_pop = 1'b1;
            data = f_head[FIFO_TX];
         end
         nxt_txsh = mode_ff[MODE_WID] ? data : {data[7:0], 8'h00};
         nxt_bit = 5'h00;
      end else if (fall) begin
         nxt_txsh = {txsh_ff[14:0], 1'b0};
      end
      // Capture MSB first; push the finished word when receive is on.
      if (rise && bit_ff < width) begin
         nxt_rxsh = {rxsh_ff[14:0], sdi_s2};
         nxt_bit = bit_ff + 5'h01;
         if (bit_ff == width - 5'h01 && mode_ff[MODE_RX] && !ctl_ff[CTL_RX_IDLE]) begin
            rx_push = 1'b1;
            rx_wdata = mode_ff[MODE_WID] ? nxt_rxsh : {8'h00, nxt_rxsh[7:0]};
         end
      end
      // A stopped interface returns every piece of the engine to rest except the receive shifter, which keeps its value.
      if (!ctl_ff[CTL_ENABLE]) begin
         nxt_bclk = 1'b0;
         nxt_hcnt = 5'h00;
         nxt_slot = 5'h00;
         nxt_lr = LR_RST;
         nxt_seen = LR_RST;
         nxt_pend = 1'b0;
         nxt_txsh = 16'h0000;
         nxt_bit = BIT_IDLE;
         tx_pop = 1'b0;
         rx_push = 1'b0;
      end
   end

   // Register the serial engine.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bclk_ff <= 1'b0;
         hcnt_ff <= 5'h00;
         slot_ff <= 5'h00;
         lr_ff <= LR_RST;
         seen_ff <= LR_RST;
         pend_ff <= 1'b0;
         txsh_ff <= 16'h0000;
         rxsh_ff <= 16'h0000;
         bit_ff <= BIT_IDLE;
      end else begin
         bclk_ff <= nxt_bclk;
         hcnt_ff <= nxt_hcnt;
         slot_ff <= nxt_slot;
         lr_ff <= nxt_lr;
         seen_ff <= nxt_seen;
         pend_ff <= nxt_pend;
         txsh_ff <= nxt_txsh;
         rxsh_ff <= nxt_rxsh;
         bit_ff <= nxt_bit;
      end
   end

   // Channel index and pin drive.
   assign lr_right = lr_ff ^ mode_ff[MODE_POL];
   assign serial_bit_clock_o = bclk_ff;
   assign frame_select_line_o = lr_ff;
   assign serial_bit_clock_oe_n_o = mode_ff[MODE_ROLE];
   assign frame_select_line_oe_n_o = mode_ff[MODE_ROLE];
   assign serial_data_out_o = txsh_ff[15];
   assign codec_clk_o = cclk_ff;
   assign bus_rdata_o = rdata_ff;
   assign bus_ack_o = ack_ff;
   assign bus_err_o = err_ff;
endmodule

// ==== dv/asmf_codec.sv ====
`timescale 1ns/1ps
// Behavioural codec on the far side of the serial link.
// It keeps every word it receives and sends one fixed word in each slot.
module asmf_codec #(
   parameter logic [15:0] WORD = 16'hA5C3 // Pattern sent in every slot.
) (
   input  wire logic bclk_i, // Bit clock as seen on the wire.
   input  wire logic fs_i,   // Frame select as seen on the wire.
   input  wire logic sdo_i,  // Data from the block.
   output logic      sdi_o   // Data to the block.
);
   logic [15:0] sh = 16'h0000; // Receive shifter.
   logic        fs_q = 1'b1;   // Frame select latched on the last rising edge.
   int          cnt = 16;      // Bits of WORD sent in this slot.
   logic [15:0] rx_q[$];       // Words received, oldest first.

   // Rising edge: take data and frame select; a frame change closes the word.
   // Falling edge: send WORD MSB first from the edge after the change, else toggle the line.
   always @(posedge bclk_i or negedge bclk_i) begin
      if (bclk_i) begin
         sh = {sh[14:0], sdo_i};
         if (fs_i != fs_q) begin
            rx_q.push_back(sh);
            cnt = 0;
         end
         fs_q = fs_i;
      end else if (cnt < 16) begin
         sdi_o <= WORD[15 - cnt];
         cnt = cnt + 1;
      end else begin
         sdi_o <= ~sdi_o;
      end
   end

   initial sdi_o = 1'b0;
endmodule

// ==== dv/asmf_core_sva.sv ====
`timescale 1ns/1ps
// Checks the register port answers and the pin direction of the audio block.
module asmf_core_sva
   import asmf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH // Entries per FIFO.
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic        bus_wr_i,
   input wire logic        bus_rd_i,
   input wire logic [1:0]  bus_size_i,
   input wire logic        bus_big_endian_i,
   input wire logic [31:0] bus_wdata_i,
   input wire logic [31:0] bus_rdata_o,
   input wire logic        bus_ack_o,
   input wire logic        bus_err_o,
   input wire logic        serial_bit_clock_i,
   input wire logic        serial_bit_clock_o,
   input wire logic        serial_bit_clock_oe_n_o,
   input wire logic        frame_select_line_i,
   input wire logic        frame_select_line_o,
   input wire logic        frame_select_line_oe_n_o,
   input wire logic        serial_data_in_i,
   input wire logic        serial_data_out_o,
   input wire logic        codec_clk_o,
   input wire logic        tx_dma_req_o,
   input wire logic        rx_dma_req_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic req = bus_wr_i | bus_rd_i; // Any access requested this cycle.

   a_resp_one_cycle: assert property (req |=> (bus_ack_o ^ bus_err_o))
      else $error("access got no single answer");
   a_no_spurious_resp: assert property ((bus_ack_o | bus_err_o) |-> $past(req))
      else $error("answer without access");
   a_mode_byte_err: assert property (req && bus_addr_i == ADDR_MODE && bus_size_i == SIZE_BYTE |=> bus_err_o)
      else $error("byte access to mode taken");
   a_fc_byte_err: assert property (req && bus_addr_i == ADDR_FIFO_CTRL && bus_size_i == SIZE_BYTE |=> bus_err_o)
      else $error("byte access to fifo control taken");
   a_psr_byte_ok: assert property (req && bus_addr_i[31:2] == ADDR_PRESCALE[31:2] && bus_size_i == SIZE_BYTE
      |=> bus_ack_o)
      else $error("byte access to prescaler refused");
   a_unmapped_err: assert property (req
      && (bus_addr_i < ADDR_CONTROL || bus_addr_i > ADDR_FIFO_PORT + 32'h3) |=> bus_err_o)
      else $error("unmapped access taken");
   a_pins_same_dir: assert property ($changed(serial_bit_clock_oe_n_o) |-> $past(bus_wr_i) && bus_ack_o
      && frame_select_line_oe_n_o == serial_bit_clock_oe_n_o)
      else $error("pin direction changed without an accepted mode write");
   a_role_follows: assert property (bus_wr_i && bus_addr_i == ADDR_MODE && bus_size_i == SIZE_WORD
      |=> serial_bit_clock_oe_n_o == $past(bus_wdata_i[MODE_ROLE]))
      else $error("pin direction does not follow role");
endmodule

bind asmf_core asmf_core_sva #(.DEPTH(DEPTH)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
   .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_size_i(bus_size_i), .bus_big_endian_i(bus_big_endian_i),
   .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o), .bus_err_o(bus_err_o),
   .serial_bit_clock_i(serial_bit_clock_i), .serial_bit_clock_o(serial_bit_clock_o),
   .serial_bit_clock_oe_n_o(serial_bit_clock_oe_n_o), .frame_select_line_i(frame_select_line_i),
   .frame_select_line_o(frame_select_line_o), .frame_select_line_oe_n_o(frame_select_line_oe_n_o),
   .serial_data_in_i(serial_data_in_i), .serial_data_out_o(serial_data_out_o), .codec_clk_o(codec_clk_o),
   .tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o));

// ==== dv/tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the audio serial block with a codec on the link.
module tb;
   import asmf_pkg::*;
   logic        clk_i, rst_i, wr, rd, be, ak, er;
   logic [1:0]  sz;
   logic [31:0] ad, wd, rq, rdata;
   logic        ack, err, bco, bcoe, fso, fsoe, sdo, sdi, cclk, txq, rxq;
   int          fail_count = 0;
   int          compares = 0;
   wire logic   bclk = bcoe ? 1'b0 : bco; // A released clock stands still.
   wire logic   fsw = fsoe ? 1'b1 : fso;

   asmf_core #(.DEPTH(FIFO_DEPTH)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(ad), .bus_wr_i(wr),
      .bus_rd_i(rd), .bus_size_i(sz), .bus_big_endian_i(be), .bus_wdata_i(wd), .bus_rdata_o(rdata),
      .bus_ack_o(ack), .bus_err_o(err), .serial_bit_clock_i(bclk), .serial_bit_clock_o(bco),
      .serial_bit_clock_oe_n_o(bcoe), .frame_select_line_i(fsw), .frame_select_line_o(fso),
      .frame_select_line_oe_n_o(fsoe), .serial_data_in_i(sdi), .serial_data_out_o(sdo),
      .codec_clk_o(cclk), .tx_dma_req_o(txq), .rx_dma_req_o(rxq));
   asmf_codec u_codec (.bclk_i(bclk), .fs_i(fsw), .sdo_i(sdo), .sdi_o(sdi));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // One access, driven on a falling edge; the answer is read half a cycle after the taking edge.
   task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] s, input logic b,
                      input logic [31:0] d);
      @(negedge clk_i);
      {wr, rd, ad, sz, be, wd} = {w, !w, a, s, b, d};
      @(negedge clk_i);
      {wr, rd} = 2'b00;
      {ak, er, rq} = {ack, err, rdata};
   endtask

   // Access that must be taken when ok is set and refused otherwise.
   task automatic ax(input logic w, input logic [31:0] a, input logic [1:0] s, input logic b,
                     input logic [31:0] d, input logic ok);
      acc(w, a, s, b, d);
      chk("response", {30'h0, ak, er}, {30'h0, ok, !ok});
   endtask

   task automatic wrw(input logic [31:0] a, input logic [31:0] d);
      ax(1'b1, a, SIZE_WORD, 1'b0, d, 1'b1);
   endtask

   task automatic rd_chk(input string n, input logic [31:0] a, input logic [31:0] e);
      acc(1'b0, a, SIZE_WORD, 1'b0, 32'h0);
      chk(n, rq, e);
   endtask

   // Reset values, access sizes, lanes and pin direction.
   task automatic t_access;
      rd_chk("mode_rst", ADDR_MODE, 32'h0);
      rd_chk("psr_rst", ADDR_PRESCALE, 32'h0);
      rd_chk("fc_rst", ADDR_FIFO_CTRL, 32'h0);
      ax(1'b1, ADDR_MODE, SIZE_BYTE, 1'b0, 32'h00FF, 1'b0);
      ax(1'b1, ADDR_MODE + HALF_BE_LANE, SIZE_HALF, 1'b1, 32'h01FF, 1'b1);
      rd_chk("mode_be", ADDR_MODE, 32'h01FF);
      chk("slave_pins", {31'h0, bcoe & fsoe}, 32'h1);
      ax(1'b1, ADDR_MODE + HALF_BE_LANE, SIZE_HALF, 1'b0, 32'h0, 1'b0);
      wrw(ADDR_MODE, 32'h0);
      chk("master_pins", {31'h0, bcoe | fsoe}, 32'h0);
      ax(1'b1, ADDR_PRESCALE, SIZE_BYTE, 1'b0, 32'h00FF, 1'b1);
      rd_chk("psr_byte", ADDR_PRESCALE, 32'h00FF);
      wrw(ADDR_PRESCALE, 32'hFFFF_FFFF);
      rd_chk("psr_word", ADDR_PRESCALE, 32'h03FF);
      ax(1'b1, ADDR_FIFO_CTRL, SIZE_BYTE, 1'b0, 32'h0, 1'b0);
      ax(1'b0, ADDR_FIFO_PORT + 32'h2, SIZE_HALF, 1'b1, 32'h0, 1'b1);
      ax(1'b0, ADDR_FIFO_PORT, SIZE_BYTE, 1'b0, 32'h0, 1'b0);
      ax(1'b0, 32'h1550_8014, SIZE_WORD, 1'b0, 32'h0, 1'b0);
      wrw(ADDR_PRESCALE, 32'h0);
   endtask

   // Fill past depth, fill counts, DMA requests and flush on disable.
   task automatic t_fifo;
      wrw(ADDR_FIFO_CTRL, 32'h0300);
      for (int i = 0; i < 9; i++) begin
         ax(1'b1, ADDR_FIFO_PORT, SIZE_HALF, 1'b0, 32'h1000 + i, 1'b1);
      end
      rd_chk("tx_full", ADDR_FIFO_CTRL, 32'h0380);
      rd_chk("rx_empty", ADDR_FIFO_PORT, 32'h0);
      wrw(ADDR_CONTROL, 32'h0030);
      wrw(ADDR_FIFO_CTRL, 32'h0F00);
      chk("dma_req", {30'h0, txq, rxq}, 32'h3);
      wrw(ADDR_FIFO_CTRL, 32'h0300);
      chk("normal_req", {30'h0, txq, rxq}, 32'h0);
      wrw(ADDR_FIFO_CTRL, 32'h0);
      rd_chk("flushed", ADDR_FIFO_CTRL, 32'h0);
      wrw(ADDR_CONTROL, 32'h0);
   endtask

   // Master, 16-bit, 32fs, standard format, both directions against the codec.
   task automatic t_link;
      logic [15:0] exp_w[3];
      int          k, n;
      exp_w = '{16'h1234, 16'h8001, 16'h4A5F};
      wrw(ADDR_FIFO_CTRL, 32'h0300);
      for (int i = 0; i < 3; i++) begin
         ax(1'b1, ADDR_FIFO_PORT, SIZE_HALF, 1'b0, {16'h0, exp_w[i]}, 1'b1);
      end
      wrw(ADDR_MODE, 32'h00C9);
      wrw(ADDR_PRESCALE, 32'h0001);
      wrw(ADDR_CONTROL, 32'h0003);
      repeat (1600) @(negedge clk_i);
      k = int'(cclk);
      @(negedge clk_i);
      chk("codec_clk", {31'h0, cclk ^ k[0]}, 32'h1);
      wrw(ADDR_CONTROL, 32'h0);
      k = 0;
      while (k < u_codec.rx_q.size() && u_codec.rx_q[k] === 16'h0) begin
         k++;
      end
      for (int i = 0; i < 3; i++) begin
         chk("tx_word", {16'h0, u_codec.rx_q[k + i]}, {16'h0, exp_w[i]});
      end
      acc(1'b0, ADDR_FIFO_CTRL, SIZE_WORD, 1'b0, 32'h0);
      n = int'(rq[3:0]);
      chk("rx_some", {31'h0, n != 0}, 32'h1);
      repeat (n) begin
         acc(1'b0, ADDR_FIFO_PORT, SIZE_HALF, 1'b0, 32'h0);
      end
      chk("rx_word", rq, 32'hA5C3);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      {wr, rd, be, sz, ad, wd} = '0;
      rst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      t_access();
      t_fifo();
      t_link();
      wrap_up();
   end
endmodule
